// file: hw/pmc_map.svh
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ***********************************************
// register offsets (byte addresses on the port)
// ***********************************************
`define PMC_ADDR_W 8
`define PMC_OFS_CTRL 8'h00
`define PMC_OFS_IDLE 8'h01
`define PMC_OFS_CPU_DIV 8'h08
`define PMC_OFS_A_DIV 8'h09
`define PMC_OFS_B_DIV 8'h0a
`define PMC_OFS_C_DIV 8'h0b
`define PMC_OFS_SYS_GATES 8'h14
`define PMC_OFS_A_GATES 8'h18

// ***********************************************
// field positions, widths and reset values
// ***********************************************
`define PMC_CFD_BIT 2
`define PMC_IDLE_W 2
`define PMC_DIV_W 3
`define PMC_SYS_GATES_N 5
`define PMC_A_GATES_N 7
`define PMC_IDLE_RST 2'h0
`define PMC_DIV_RST 3'h0
`define PMC_SYS_GATES_RST 7'h7f
`define PMC_A_GATES_RST 7'h7f
`define PMC_GATES_W 7
`define PMC_IDLE_CPU 2'h0
`define PMC_IDLE_AHB 2'h1
`define PMC_IDLE_APB 2'h2

`endif

// file: hw/pmc_pkg.sv
package pmc_pkg;

    // idle sequencer states, one-hot
    typedef enum logic [1:0] {
        PMC_RUN = 2'h1,
        PMC_IDLE = 2'h2
    } pmc_state_e;

endpackage

// file: hw/pmc_clk_div.sv
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_clk_div #(
    parameter int CODE_W = `PMC_DIV_W,
    parameter int CNT_W = 7
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [CODE_W-1:0] div_code,
    output logic tick_q
);

    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CODE_W-1:0] code_q, code_d;
    logic [CNT_W-1:0] last;
    logic tick_d;

    // ***********************************************
    // power-of-two prescaler
    // ***********************************************
    // a new code is only taken at a period boundary so no period is cut short
    always_comb
    begin
        last = CNT_W'((1 << code_q) - 1);
        tick_d = (cnt_q == last);
        cnt_d = tick_d ? '0 : cnt_q + 1'b1;
        code_d = tick_d ? div_code : code_q;
    end

    // every division is counted on sys_clk, so all ticks stay aligned
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cnt_q <= '0;
            code_q <= `PMC_DIV_RST;
            tick_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            code_q <= code_d;
            tick_q <= tick_d;
        end
    end

endmodule // pmc_clk_div

// file: hw/pmc_clock_gating.sv
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_clock_gating #(
    parameter int DATA_W = 32
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [`PMC_ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata_q,
    input wire logic write_protect,
    input wire logic clock_fail_pin,
    input wire logic wait_for_interrupt,
    input wire logic wake_request,
    output logic clock_fail_detect_enable_q,
    output logic processor_clk_en_q,
    output logic [`PMC_SYS_GATES_N-1:0] sys_clk_en_q,
    output logic [`PMC_A_GATES_N-1:0] bus_a_clk_en_q,
    output logic bus_b_clk_en_q,
    output logic bus_c_clk_en_q,
    output logic [`PMC_IDLE_W-1:0] idle_stage_q
);

    // ***********************************************
    // registers and next values
    // ***********************************************
    logic cfd_en_q, cfd_en_d;
    logic [`PMC_IDLE_W-1:0] idle_cfg_q, idle_cfg_d;
    logic [`PMC_DIV_W-1:0] cpu_div_q, cpu_div_d;
    logic [`PMC_DIV_W-1:0] a_div_q, a_div_d;
    logic [`PMC_DIV_W-1:0] b_div_q, b_div_d;
    logic [`PMC_DIV_W-1:0] c_div_q, c_div_d;
    logic [`PMC_GATES_W-1:0] sys_gates_q, sys_gates_d;
    logic [`PMC_GATES_W-1:0] a_gates_q, a_gates_d;
    logic [DATA_W-1:0] rdata_d;
    logic fail_meta_q, fail_sync_q;
    logic wr_ok;

    // ***********************************************
    // register writes
    // ***********************************************
    // a write while protected is dropped without any answer
    always_comb
    begin
        wr_ok = reg_wr && !write_protect;
        cfd_en_d = cfd_en_q;
        idle_cfg_d = idle_cfg_q;
        cpu_div_d = cpu_div_q;
        a_div_d = a_div_q;
        b_div_d = b_div_q;
        c_div_d = c_div_q;
        sys_gates_d = sys_gates_q;
        a_gates_d = a_gates_q;
        if (wr_ok)
        begin
            unique case (reg_addr)
                `PMC_OFS_CTRL: cfd_en_d = reg_wdata[`PMC_CFD_BIT];
                `PMC_OFS_IDLE: idle_cfg_d = reg_wdata[`PMC_IDLE_W-1:0];
                `PMC_OFS_CPU_DIV: cpu_div_d = reg_wdata[`PMC_DIV_W-1:0];
                `PMC_OFS_A_DIV: a_div_d = reg_wdata[`PMC_DIV_W-1:0];
                `PMC_OFS_B_DIV: b_div_d = reg_wdata[`PMC_DIV_W-1:0];
                `PMC_OFS_C_DIV: c_div_d = reg_wdata[`PMC_DIV_W-1:0];
                `PMC_OFS_SYS_GATES:
                    sys_gates_d = reg_wdata[`PMC_GATES_W-1:0];
                `PMC_OFS_A_GATES: a_gates_d = reg_wdata[`PMC_GATES_W-1:0];
                default: ;
            endcase
        end
        // hardware set wins over a software clear in the same cycle
        if (fail_sync_q)
            cfd_en_d = 1'b1;
    end

    // ***********************************************
    // register reads
    // ***********************************************
    // unmapped and reserved bits read as zero
    always_comb
    begin
        rdata_d = '0;
        if (reg_rd)
        begin
            unique case (reg_addr)
                `PMC_OFS_CTRL: rdata_d[`PMC_CFD_BIT] = cfd_en_q;
                `PMC_OFS_IDLE: rdata_d[`PMC_IDLE_W-1:0] = idle_cfg_q;
                `PMC_OFS_CPU_DIV: rdata_d[`PMC_DIV_W-1:0] = cpu_div_q;
                `PMC_OFS_A_DIV: rdata_d[`PMC_DIV_W-1:0] = a_div_q;
                `PMC_OFS_B_DIV: rdata_d[`PMC_DIV_W-1:0] = b_div_q;
                `PMC_OFS_C_DIV: rdata_d[`PMC_DIV_W-1:0] = c_div_q;
                `PMC_OFS_SYS_GATES: rdata_d[`PMC_GATES_W-1:0] = sys_gates_q;
                `PMC_OFS_A_GATES: rdata_d[`PMC_GATES_W-1:0] = a_gates_q;
                default: ;
            endcase
        end
    end

    // register file and read data
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            cfd_en_q <= 1'b0;
            idle_cfg_q <= `PMC_IDLE_RST;
            cpu_div_q <= `PMC_DIV_RST;
            a_div_q <= `PMC_DIV_RST;
            b_div_q <= `PMC_DIV_RST;
            c_div_q <= `PMC_DIV_RST;
            sys_gates_q <= `PMC_SYS_GATES_RST;
            a_gates_q <= `PMC_A_GATES_RST;
            reg_rdata_q <= '0;
        end
        else
        begin
            cfd_en_q <= cfd_en_d;
            idle_cfg_q <= idle_cfg_d;
            cpu_div_q <= cpu_div_d;
            a_div_q <= a_div_d;
            b_div_q <= b_div_d;
            c_div_q <= c_div_d;
            sys_gates_q <= sys_gates_d;
            a_gates_q <= a_gates_d;
            reg_rdata_q <= rdata_d;
        end
    end

    // ***********************************************
    // clock failure pin synchroniser
    // ***********************************************
    // the failure pin comes from the analog side, so it is double sampled
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            fail_meta_q <= 1'b0;
            fail_sync_q <= 1'b0;
        end
        else
        begin
            fail_meta_q <= clock_fail_pin;
            fail_sync_q <= fail_meta_q;
        end
    end

    // ***********************************************
    // idle sequencer
    // ***********************************************
    pmc_pkg::pmc_state_e state_q, state_d;
    logic [`PMC_IDLE_W-1:0] stage_q, stage_d;
    logic stop_cpu, stop_sys, stop_bus;

    // the depth is latched on entry so a later write cannot deepen sleep
    always_comb
    begin
        state_d = state_q;
        stage_d = stage_q;
        unique case (state_q)
            pmc_pkg::PMC_RUN:
                if (wait_for_interrupt && !wake_request)
                begin
                    state_d = pmc_pkg::PMC_IDLE;
                    stage_d = idle_cfg_q;
                end
            pmc_pkg::PMC_IDLE:
                if (wake_request)
                    state_d = pmc_pkg::PMC_RUN;
            default: state_d = pmc_pkg::PMC_RUN;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            state_q <= pmc_pkg::PMC_RUN;
            stage_q <= `PMC_IDLE_RST;
        end
        else
        begin
            state_q <= state_d;
            stage_q <= stage_d;
        end
    end

    // reserved code 3 is treated like the deepest idle level
    assign stop_cpu = (state_q == pmc_pkg::PMC_IDLE);
    assign stop_sys = stop_cpu && (stage_q >= `PMC_IDLE_AHB);
    assign stop_bus = stop_cpu && (stage_q >= `PMC_IDLE_APB);

    // ***********************************************
    // prescalers
    // ***********************************************
    logic cpu_tick, a_tick, b_tick, c_tick;

    pmc_clk_div u_cpu_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .div_code(cpu_div_q),
        .tick_q(cpu_tick)
    );

    pmc_clk_div u_a_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .div_code(a_div_q),
        .tick_q(a_tick)
    );

    pmc_clk_div u_b_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .div_code(b_div_q),
        .tick_q(b_tick)
    );

    pmc_clk_div u_c_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .div_code(c_div_q),
        .tick_q(c_tick)
    );

    // ***********************************************
    // gated clock enables
    // ***********************************************
    // enables are whole sys_clk pulses, so a gate change never clips one
    logic proc_en_d, b_en_d, c_en_d;
    logic [`PMC_SYS_GATES_N-1:0] sys_en_d;
    logic [`PMC_A_GATES_N-1:0] a_en_d;

    always_comb
    begin
        proc_en_d = cpu_tick && !stop_cpu;
        b_en_d = b_tick && !stop_bus;
        c_en_d = c_tick && !stop_bus;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `PMC_SYS_GATES_N; gi++)
        begin : g_sys
            // bit 4 memory ctrl, 3 debug, 2..0 bridges
            assign sys_en_d[gi] = cpu_tick && !stop_sys
                && sys_gates_q[gi];
        end
        for (gi = 0; gi < `PMC_A_GATES_N; gi++)
        begin : g_bus_a
            // bit 6 interrupts, 5 rtc, 4 watchdog, 3..0 system blocks
            assign a_en_d[gi] = a_tick && !stop_bus
                && a_gates_q[gi];
        end
    endgenerate

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            processor_clk_en_q <= 1'b0;
            sys_clk_en_q <= '0;
            bus_a_clk_en_q <= '0;
            bus_b_clk_en_q <= 1'b0;
            bus_c_clk_en_q <= 1'b0;
            clock_fail_detect_enable_q <= 1'b0;
            idle_stage_q <= `PMC_IDLE_RST;
        end
        else
        begin
            processor_clk_en_q <= proc_en_d;
            sys_clk_en_q <= sys_en_d;
            bus_a_clk_en_q <= a_en_d;
            bus_b_clk_en_q <= b_en_d;
            bus_c_clk_en_q <= c_en_d;
            clock_fail_detect_enable_q <= cfd_en_d;
            idle_stage_q <= stop_cpu ? stage_q : `PMC_IDLE_RST;
        end
    end

endmodule // pmc_clock_gating

// file: dv/pmc_clock_gating_assertions.sv
`timescale 1ns/1ps
`include "pmc_map.svh"

// ****************************************
// port checks for the clock gating block
// ****************************************
module pmc_clock_gating_assertions #(
    parameter int DATA_W = 32
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [`PMC_ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata_q,
    input wire logic write_protect,
    input wire logic clock_fail_pin,
    input wire logic wait_for_interrupt,
    input wire logic wake_request,
    input wire logic clock_fail_detect_enable_q,
    input wire logic processor_clk_en_q,
    input wire logic [`PMC_SYS_GATES_N-1:0] sys_clk_en_q,
    input wire logic [`PMC_A_GATES_N-1:0] bus_a_clk_en_q,
    input wire logic bus_b_clk_en_q,
    input wire logic bus_c_clk_en_q,
    input wire logic [`PMC_IDLE_W-1:0] idle_stage_q
);
    logic [2:0] fail_q;
    logic [2:0][6:0] sg_q;
    logic [2:0][6:0] ag_q;
    logic wr_ok;
    logic [6:0] sys_ok;
    logic [6:0] a_ok;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // masks kept three edges deep: a change may land at any of them
    assign wr_ok = reg_wr && !write_protect;
    assign sys_ok = sg_q[0] | sg_q[1] | sg_q[2];
    assign a_ok = ag_q[0] | ag_q[1] | ag_q[2];
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            fail_q <= 3'h0;
            sg_q <= {3{7'h7f}};
            ag_q <= {3{7'h7f}};
        end
        else
        begin
            fail_q <= {fail_q[1:0], clock_fail_pin};
            sg_q <= {sg_q[1:0], (wr_ok && reg_addr == 8'h14) ?
                reg_wdata[6:0] : sg_q[0]};
            ag_q <= {ag_q[1:0], (wr_ok && reg_addr == 8'h18) ?
                reg_wdata[6:0] : ag_q[0]};
        end
    end

    chk_cfd_write: assert property (
        wr_ok && reg_addr == 8'h00 && !clock_fail_pin && fail_q == 3'h0
        |=> clock_fail_detect_enable_q == $past(reg_wdata[2]))
        else $error("detector enable differs from written bit");
    chk_fail_sets: assert property (
        clock_fail_pin [*3] |=> clock_fail_detect_enable_q)
        else $error("clock failure did not set detector enable");
    chk_protect_hold: assert property (
        write_protect && reg_wr && reg_addr == 8'h00 && !clock_fail_pin
        && fail_q == 3'h0 |=> $stable(clock_fail_detect_enable_q))
        else $error("protected write changed detector enable");
    chk_wait_stop: assert property (
        (wait_for_interrupt && !wake_request && !$past(wake_request))
        ##1 !wake_request [*2] |-> !processor_clk_en_q)
        else $error("processor clock still runs after wait");
    chk_idle_sys: assert property (
        idle_stage_q != 2'h0 |-> !processor_clk_en_q && sys_clk_en_q == '0)
        else $error("system bus clock runs in deep idle");
    chk_idle_bus: assert property (
        idle_stage_q[1] |->
        {bus_a_clk_en_q, bus_b_clk_en_q, bus_c_clk_en_q} == '0)
        else $error("peripheral bus clock runs in deepest idle");
    chk_sys_gate: assert property (
        (sys_clk_en_q & ~sys_ok[4:0]) == '0)
        else $error("masked system bus client got a pulse");
    chk_a_gate: assert property (
        (bus_a_clk_en_q & ~a_ok) == '0)
        else $error("masked bus A client got a pulse");

    cover property (processor_clk_en_q && bus_a_clk_en_q[6]);
    cover property (idle_stage_q == 2'h2);
    cover property (clock_fail_pin [*3] ##1 clock_fail_detect_enable_q);
endmodule // pmc_clock_gating_assertions

bind pmc_clock_gating pmc_clock_gating_assertions #(.DATA_W(DATA_W)) i_chk (
    .sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .write_protect(write_protect),
    .clock_fail_pin(clock_fail_pin),
    .wait_for_interrupt(wait_for_interrupt), .wake_request(wake_request),
    .clock_fail_detect_enable_q(clock_fail_detect_enable_q),
    .processor_clk_en_q(processor_clk_en_q), .sys_clk_en_q(sys_clk_en_q),
    .bus_a_clk_en_q(bus_a_clk_en_q), .bus_b_clk_en_q(bus_b_clk_en_q),
    .bus_c_clk_en_q(bus_c_clk_en_q), .idle_stage_q(idle_stage_q)
);

// file: dv/pmc_clock_gating_tb.sv
`timescale 1ns/1ps

module pmc_clock_gating_tb;
    logic sys_clk, nrst, reg_wr, reg_rd, write_protect, clock_fail_pin;
    logic wait_for_interrupt, wake_request, cfd_en, cpu_en, b_en, c_en;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, rdata;
    logic [4:0] sys_en;
    logic [6:0] a_en;
    logic [1:0] stage;
    logic [14:0] seen;
    int cnt [15];
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;
    logic [7:0] ofs [9] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0a, 8'h0b,
        8'h14, 8'h18, 8'h04};
    logic [31:0] rst_v [9] = '{0, 0, 0, 0, 0, 0, 32'h7f, 32'h7f, 0};
    // idle code 3 is reserved, so the near all-ones pattern keeps bit 0 clear
    logic [31:0] ones_v [9] = '{4, 2, 6, 6, 6, 6, 32'h7e, 32'h7e, 0};
    int div_bit [4] = '{14, 2, 1, 0};

    pmc_clock_gating i_dut (.sys_clk(sys_clk), .nrst(nrst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_q(rdata), .write_protect(write_protect),
        .clock_fail_pin(clock_fail_pin),
        .wait_for_interrupt(wait_for_interrupt),
        .wake_request(wake_request), .clock_fail_detect_enable_q(cfd_en),
        .processor_clk_en_q(cpu_en), .sys_clk_en_q(sys_en),
        .bus_a_clk_en_q(a_en), .bus_b_clk_en_q(b_en), .bus_c_clk_en_q(c_en),
        .idle_stage_q(stage));

    // ****************************************
    // clock, access tasks and reporting
    // ****************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task cmp(logic [31:0] got, logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task wr(logic [7:0] a, logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task rd(logic [7:0] a, logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        cmp(rdata, exp);
    endtask

    // collect which enables pulsed and how often, sampled once settled
    task watch(int n);
        logic [14:0] v;
        seen = '0;
        foreach (cnt[i]) cnt[i] = 0;
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
            v = {cpu_en, sys_en, a_en, b_en, c_en};
            seen |= v;
            foreach (cnt[i]) cnt[i] += int'(v[i]);
        end
    endtask

    task test_done;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // a hung handshake would otherwise run forever
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            n_mismatch++;
            test_done;
        end
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial
    begin
        {nrst, reg_wr, reg_rd, write_protect, clock_fail_pin} = '0;
        {wait_for_interrupt, wake_request, reg_addr, reg_wdata} = '0;
        repeat (12) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int i = 0; i < 9; i++) rd(ofs[i], rst_v[i]);
        for (int i = 0; i < 9; i++) wr(ofs[i], 32'hfffffffe);
        for (int i = 0; i < 9; i++) rd(ofs[i], ones_v[i]);
        cmp(cfd_en, 1);
        for (int i = 0; i < 9; i++) wr(ofs[i], rst_v[i]);
        rd(8'h00, 0);
        $display("test registers done");
        // inputs only move right after a rising edge
        @(posedge sys_clk);
        write_protect <= 1'b1;
        wr(8'h08, 5);
        wr(8'h00, 4);
        write_protect <= 1'b0;
        rd(8'h08, 0);
        rd(8'h00, 0);
        $display("test protection done");
        @(posedge sys_clk);
        clock_fail_pin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        clock_fail_pin <= 1'b0;
        rd(8'h00, 4);
        wr(8'h00, 0);
        rd(8'h00, 0);
        $display("test clock failure done");
        for (int r = 0; r < 4; r++)
        begin
            for (int c = 0; c < 8; c++)
            begin
                wr(8'h08 + 8'(r), c);
                watch(130);
                watch(256);
                cmp(cnt[div_bit[r]], 256 >> c);
            end
            wr(8'h08 + 8'(r), 0);
            watch(130);
        end
        $display("test dividers done");
        wr(8'h14, 32'h15);
        wr(8'h18, 32'h2a);
        watch(3);
        watch(8);
        cmp(seen, {1'b1, 5'h15, 7'h2a, 2'h3});
        wr(8'h14, 32'h7f);
        wr(8'h18, 32'h7f);
        $display("test gates done");
        for (int d = 0; d < 3; d++)
        begin
            wr(8'h01, d);
            wait_for_interrupt <= 1'b1;
            @(posedge sys_clk);
            wait_for_interrupt <= 1'b0;
            watch(3);
            watch(8);
            cmp(stage, d);
            cmp(seen, {1'b0, d > 0 ? 5'h0 : 5'h1f, d > 1 ? 9'h0 : 9'h1ff});
            @(posedge sys_clk);
            wake_request <= 1'b1;
            @(posedge sys_clk);
            wake_request <= 1'b0;
            watch(4);
            watch(8);
            cmp(seen, 15'h7fff);
        end
        $display("test idle done");
        test_done;
    end
endmodule // pmc_clock_gating_tb
